//--- shared/nvsrc_pkg.sv
// Constants and types shared by the nonvolatile SRAM host controller.
`default_nettype none
package nvsrc_pkg;
    localparam int ADDR_W       = 11;
    localparam int DATA_W       = 8;
    localparam int SEQ_LEN      = 6;
    localparam int CLK_FREQ_KHZ = 200000;
    localparam int CLK_FREQ_MHZ = 200;

    // Times as printed, each in its own unit.
    localparam int SEL_PULSE_NS    = 45;
    localparam int SEL_GAP_NS      = 45;
    localparam int STORE_TIME_MS   = 10;
    localparam int RECALL_TIME_US  = 20;
    localparam int RESTORE_TIME_US = 650;

    // Least times round up to whole cycles.
    localparam int SEL_PULSE_CYC =
        (SEL_PULSE_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int SEL_GAP_CYC =
        (SEL_GAP_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int STORE_CYC   = STORE_TIME_MS * CLK_FREQ_KHZ;
    localparam int RECALL_CYC  = RECALL_TIME_US * CLK_FREQ_MHZ;
    localparam int RESTORE_CYC = RESTORE_TIME_US * CLK_FREQ_MHZ;
    localparam int CNT_W       = 21;

    localparam logic [10:0] SEQ_A0        = 11'h000;
    localparam logic [10:0] SEQ_A1        = 11'h555;
    localparam logic [10:0] SEQ_A2        = 11'h2AA;
    localparam logic [10:0] SEQ_A3        = 11'h7FF;
    localparam logic [10:0] SEQ_A4        = 11'h0F0;
    localparam logic [10:0] SEQ_STORE_A5  = 11'h70F;
    localparam logic [10:0] SEQ_RECALL_A5 = 11'h70E;

    typedef enum logic [1:0] {
        NVSRC_OP_READ   = 2'h0,
        NVSRC_OP_WRITE  = 2'h1,
        NVSRC_OP_STORE  = 2'h2,
        NVSRC_OP_RECALL = 2'h3
    } nvsrc_op_t;

    typedef struct packed {
        logic              valid;
        nvsrc_op_t         op;
        logic [10:0]       addr;
        logic [7:0]        wdata;
    } nvsrc_req_t;

    typedef struct packed {
        logic              done;
        logic              refused;
        logic [7:0]        rdata;
    } nvsrc_resp_t;

    typedef struct packed {
        logic              chip_sel_n;
        logic              out_en_n;
        logic              write_n;
        logic [10:0]       address_lines;
        logic [7:0]        data_out;
        logic              data_oe;
    } nvsrc_pins_t;

    localparam nvsrc_pins_t PINS_IDLE = '{
        chip_sel_n: 1'b1, out_en_n: 1'b1, write_n: 1'b1,
        address_lines: 11'h000, data_out: 8'h00, data_oe: 1'b0};
endpackage : nvsrc_pkg
`default_nettype wire

//--- hw/nvsrc_timer.sv
// Loadable down counter that times select pulses and nonvolatile cycles.
`default_nettype none
module nvsrc_timer #(
    parameter int CNT_W = 21
) (
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] value,
    output logic                  zero
);
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;

    always_comb
    begin
        cnt_next = cnt_reg;
        if (load)
        begin
            cnt_next = value;
        end
        else if (cnt_reg != '0)
        begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            cnt_reg <= '0;
        end
        else
        begin
            cnt_reg <= cnt_next;
        end
    end

    assign zero = (cnt_reg == '0);
endmodule : nvsrc_timer
`default_nettype wire

//--- hw/nvsrc_host.sv
// Host controller driving a nonvolatile SRAM through its parallel pins.
// Functional notes
// - Keep output enable high through writes.
// - Never hold write strobe when recall ends.
// - Store sequence 000,555,2AA,7FF,0F0,70F reads.
// - Recall sequence ends with address 70E.
// - No other access inside the sequence.
// - Sequence steps are reads, write strobe high.
// - One select pulse per sequence address.
// - Write strobe high while selected in sequence.
`default_nettype none
module nvsrc_host #(
    parameter int STORE_CYC   = nvsrc_pkg::STORE_CYC,
    parameter int RECALL_CYC  = nvsrc_pkg::RECALL_CYC,
    parameter int RESTORE_CYC = nvsrc_pkg::RESTORE_CYC
) (
    input  wire logic                   ref_clk,
    input  wire logic                   reset,
    input  wire logic                   supply_ok,
    input  wire nvsrc_pkg::nvsrc_req_t  req,
    output logic                        ready,
    output nvsrc_pkg::nvsrc_resp_t      resp,
    output nvsrc_pkg::nvsrc_pins_t      pins,
    input  wire logic [7:0]             data_lines_in
);
    localparam int CW = nvsrc_pkg::CNT_W;

    typedef enum logic [5:0] {
        NVSRC_ST_PWRDN  = 6'h01,
        NVSRC_ST_PWRUP  = 6'h02,
        NVSRC_ST_IDLE   = 6'h04,
        NVSRC_ST_ACCESS = 6'h08,
        NVSRC_ST_GAP    = 6'h10,
        NVSRC_ST_NVWAIT = 6'h20
    } nvsrc_state_t;

    nvsrc_state_t           state_reg;
    nvsrc_state_t           state_next;
    nvsrc_pkg::nvsrc_op_t   op_reg;
    nvsrc_pkg::nvsrc_op_t   op_next;
    logic [2:0]             step_reg;
    logic [2:0]             step_next;
    logic                   busy_reg;
    logic                   busy_next;
    logic                   ready_reg;
    logic                   ready_next;
    nvsrc_pkg::nvsrc_resp_t resp_reg;
    nvsrc_pkg::nvsrc_resp_t resp_next;
    nvsrc_pkg::nvsrc_pins_t pins_reg;
    nvsrc_pkg::nvsrc_pins_t pins_next;
    logic                   tmr_load;
    logic [CW-1:0]          tmr_value;
    logic                   tmr_zero;

    function automatic logic [10:0] seq_addr(input logic [2:0] step,
                                             input logic       recall);
        logic [10:0] a;
        a = nvsrc_pkg::SEQ_A0;
        case (step)
            3'h1: a = nvsrc_pkg::SEQ_A1;
            3'h2: a = nvsrc_pkg::SEQ_A2;
            3'h3: a = nvsrc_pkg::SEQ_A3;
            3'h4: a = nvsrc_pkg::SEQ_A4;
            3'h5: a = recall ? nvsrc_pkg::SEQ_RECALL_A5
                             : nvsrc_pkg::SEQ_STORE_A5;
            default: a = nvsrc_pkg::SEQ_A0;
        endcase
        return a;
    endfunction : seq_addr

    nvsrc_timer #(
        .CNT_W (CW)
    ) u_timer (
        .ref_clk (ref_clk),
        .reset   (reset),
        .load    (tmr_load),
        .value   (tmr_value),
        .zero    (tmr_zero)
    );

    always_comb
    begin
        state_next = state_reg;
        op_next    = op_reg;
        step_next  = step_reg;
        busy_next  = busy_reg;
        pins_next  = pins_reg;
        resp_next  = resp_reg;
        resp_next.done    = 1'b0;
        resp_next.refused = 1'b0;
        tmr_load   = 1'b0;
        tmr_value  = '0;
        if (!supply_ok)
        begin
            // A store cut short by low supply is lost; report it refused.
            state_next = NVSRC_ST_PWRDN;
            pins_next  = nvsrc_pkg::PINS_IDLE;
            step_next  = 3'h0;
            if (busy_reg)
            begin
                resp_next.done    = 1'b1;
                resp_next.refused = 1'b1;
            end
            busy_next = 1'b0;
        end
        else
        begin
            case (state_reg)
                NVSRC_ST_PWRDN:
                begin
                    // The device recalls on its own as the supply returns.
                    tmr_load   = 1'b1;
                    tmr_value  = CW'(RESTORE_CYC - 1);
                    state_next = NVSRC_ST_PWRUP;
                end
                NVSRC_ST_PWRUP:
                begin
                    // Write strobe held high until the recall is over.
                    if (tmr_zero)
                    begin
                        state_next = NVSRC_ST_IDLE;
                    end
                end
                NVSRC_ST_IDLE:
                begin
                    if (req.valid)
                    begin
                        op_next   = req.op;
                        busy_next = 1'b1;
                        step_next = 3'h0;
                        tmr_load  = 1'b1;
                        tmr_value = CW'(nvsrc_pkg::SEL_PULSE_CYC - 1);
                        pins_next.chip_sel_n = 1'b0;
                        pins_next.out_en_n   = 1'b1;
                        pins_next.write_n    = 1'b1;
                        pins_next.data_oe    = 1'b0;
                        pins_next.address_lines = req.addr;
                        if (req.op == nvsrc_pkg::NVSRC_OP_READ)
                        begin
                            pins_next.out_en_n = 1'b0;
                        end
                        else if (req.op == nvsrc_pkg::NVSRC_OP_WRITE)
                        begin
                            pins_next.write_n  = 1'b0;
                            pins_next.data_oe  = 1'b1;
                            pins_next.data_out = req.wdata;
                        end
                        else
                        begin
                            pins_next.address_lines =
                                seq_addr(3'h0, req.op[0]);
                        end
                        state_next = NVSRC_ST_ACCESS;
                    end
                end
                NVSRC_ST_ACCESS:
                begin
                    if (tmr_zero)
                    begin
                        // Only a plain read may replace the held read data.
                        if (op_reg == nvsrc_pkg::NVSRC_OP_READ)
                        begin
                            resp_next.rdata = data_lines_in;
                        end
                        pins_next.chip_sel_n = 1'b1;
                        pins_next.out_en_n   = 1'b1;
                        pins_next.write_n    = 1'b1;
                        pins_next.data_oe    = 1'b0;
                        tmr_load   = 1'b1;
                        tmr_value  = CW'(nvsrc_pkg::SEL_GAP_CYC - 1);
                        state_next = NVSRC_ST_GAP;
                    end
                end
                NVSRC_ST_GAP:
                begin
                    if (tmr_zero)
                    begin
                        if (op_reg[1] &&
                            step_reg != 3'(nvsrc_pkg::SEQ_LEN - 1))
                        begin
                            // Back to back reads, nothing in between.
                            step_next = step_reg + 3'h1;
                            pins_next.address_lines =
                                seq_addr(step_reg + 3'h1, op_reg[0]);
                            pins_next.chip_sel_n = 1'b0;
                            tmr_load   = 1'b1;
                            tmr_value  =
                                CW'(nvsrc_pkg::SEL_PULSE_CYC - 1);
                            state_next = NVSRC_ST_ACCESS;
                        end
                        else if (op_reg[1])
                        begin
                            // The device ignores the pins for this time.
                            tmr_load  = 1'b1;
                            tmr_value = op_reg[0]
                                ? CW'(RECALL_CYC - 1)
                                : CW'(STORE_CYC - 1);
                            state_next = NVSRC_ST_NVWAIT;
                        end
                        else
                        begin
                            resp_next.done = 1'b1;
                            busy_next  = 1'b0;
                            state_next = NVSRC_ST_IDLE;
                        end
                    end
                end
                NVSRC_ST_NVWAIT:
                begin
                    if (tmr_zero)
                    begin
                        resp_next.done = 1'b1;
                        busy_next  = 1'b0;
                        step_next  = 3'h0;
                        state_next = NVSRC_ST_IDLE;
                    end
                end
                default:
                begin
                    state_next = NVSRC_ST_PWRDN;
                end
            endcase
        end
        ready_next = (state_next == NVSRC_ST_IDLE) && !req.valid;
        if (state_next == NVSRC_ST_IDLE && state_reg != NVSRC_ST_IDLE)
        begin
            ready_next = 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            state_reg <= NVSRC_ST_PWRDN;
            op_reg    <= nvsrc_pkg::NVSRC_OP_READ;
            step_reg  <= 3'h0;
            busy_reg  <= 1'b0;
            ready_reg <= 1'b0;
            resp_reg  <= '0;
            pins_reg  <= nvsrc_pkg::PINS_IDLE;
        end
        else
        begin
            state_reg <= state_next;
            op_reg    <= op_next;
            step_reg  <= step_next;
            busy_reg  <= busy_next;
            ready_reg <= ready_next;
            resp_reg  <= resp_next;
            pins_reg  <= pins_next;
        end
    end

    assign ready = ready_reg;
    assign resp  = resp_reg;
    assign pins  = pins_reg;
endmodule : nvsrc_host
`default_nettype wire

//--- sim/nvsrc_host_asserts.sv
// Concurrent checks on the pins and handshake of the host controller.
`default_nettype none
module nvsrc_host_asserts (
    input wire logic                   ref_clk,
    input wire logic                   reset,
    input wire logic                   supply_ok,
    input wire nvsrc_pkg::nvsrc_req_t  req,
    input wire logic                   ready,
    input wire nvsrc_pkg::nvsrc_resp_t resp,
    input wire nvsrc_pkg::nvsrc_pins_t pins,
    input wire logic [7:0]             data_lines_in
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_sel_low;
        !pins.chip_sel_n [*8] ##1 !pins.chip_sel_n ##1 pins.chip_sel_n;
    endsequence
    sequence s_rw_taken;
        ready && req.valid && !req.op[1];
    endsequence

    property p_oe_in_write;
        !pins.write_n |-> pins.out_en_n;
    endproperty
    a_oe_in_write: assert property (p_oe_in_write)
        else $error("output enable low during write");
    property p_drive_in_write;
        pins.data_oe |-> !pins.write_n && !pins.chip_sel_n;
    endproperty
    a_drive_in_write: assert property (p_drive_in_write)
        else $error("data driven outside a write");
    property p_pulse_len;
        disable iff (reset || !supply_ok)
        $fell(pins.chip_sel_n) |-> s_sel_low;
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("select pulse not nine cycles");
    property p_gap_len;
        $rose(pins.chip_sel_n) |-> pins.chip_sel_n [*8];
    endproperty
    a_gap_len: assert property (p_gap_len)
        else $error("select gap too short");
    property p_addr_hold;
        !pins.chip_sel_n && !$fell(pins.chip_sel_n)
            |-> $stable(pins.address_lines);
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("address moved inside select pulse");
    property p_supply_abort;
        !supply_ok |=> pins.chip_sel_n && pins.write_n && !pins.data_oe;
    endproperty
    a_supply_abort: assert property (p_supply_abort)
        else $error("pins not idle after supply loss");
    property p_done_ready;
        resp.done && !resp.refused |-> ready ##1 !resp.done;
    endproperty
    a_done_ready: assert property (p_done_ready)
        else $error("done pulse without ready");
    property p_rw_latency;
        disable iff (reset || !supply_ok)
        s_rw_taken |=> !ready [*8] ##11 resp.done;
    endproperty
    a_rw_latency: assert property (p_rw_latency)
        else $error("read or write answer late");
endmodule : nvsrc_host_asserts
`default_nettype wire

//--- sim/nvsrc_dev_model.sv
// Behavioural nonvolatile SRAM answering the host controller's pins.
`default_nettype none
module nvsrc_dev_model #(
    parameter int BUSY_ST = 40,
    parameter int BUSY_RC = 15
) (
    input  wire logic                   ref_clk,
    input  wire logic                   supply_ok,
    input  wire nvsrc_pkg::nvsrc_pins_t pins,
    output var  logic [7:0]             data_lines_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  sram_reg [2048];
    logic [7:0]  nv_reg   [2048];
    logic [10:0] seq_tbl  [5] = '{11'h000, 11'h555, 11'h2AA, 11'h7FF,
                                  11'h0F0};
    logic [7:0]  last_reg  = 8'h00;
    logic        sel_reg   = 1'b1;
    logic        sup_reg   = 1'b1;
    logic        wseen_reg = 1'b0;
    int          step_reg  = 0;
    int          busy_reg  = 0;
    logic        drive;

    // A released bus shows the inverse of its last value, never a hold.
    assign drive = !pins.chip_sel_n && !pins.out_en_n && pins.write_n
                   && busy_reg == 0 && supply_ok;
    always_comb data_lines_in = drive ? sram_reg[pins.address_lines]
                                      : ~last_reg;

    task automatic do_store;
        foreach (nv_reg[i]) nv_reg[i] = 8'hFF;
        foreach (nv_reg[i]) nv_reg[i] = sram_reg[i];
        wseen_reg = 1'b0;
        busy_reg = BUSY_ST;
    endtask : do_store

    task automatic do_recall;
        foreach (sram_reg[i]) sram_reg[i] = 8'h00;
        foreach (sram_reg[i]) sram_reg[i] = nv_reg[i];
        wseen_reg = 1'b0;
        busy_reg = BUSY_RC;
    endtask : do_recall

    initial
    begin
        foreach (nv_reg[i]) nv_reg[i] = 8'h00;
        foreach (sram_reg[i]) sram_reg[i] = 8'h00;
    end

    // The falling edge keeps every change away from the host's sampling edge.
    always @(negedge ref_clk)
    begin
        if (drive)
            last_reg <= data_lines_in;
        sel_reg <= pins.chip_sel_n;
        sup_reg <= supply_ok;
        if (busy_reg > 0)
            busy_reg = busy_reg - 1;
        if (sup_reg && !supply_ok && wseen_reg)
            do_store();
        else if (!sup_reg && supply_ok)
            do_recall();
        else if (supply_ok && busy_reg == 0 && sel_reg && !pins.chip_sel_n)
        begin
            if (!pins.write_n)
            begin
                sram_reg[pins.address_lines] = pins.data_out;
                wseen_reg = 1'b1;
                step_reg = 0;
            end
            else if (step_reg == 5)
            begin
                if (pins.address_lines == 11'h70F)
                    do_store();
                else if (pins.address_lines == 11'h70E)
                    do_recall();
                step_reg = 0;
            end
            else if (pins.address_lines == seq_tbl[step_reg])
                step_reg = step_reg + 1;
            else
                step_reg = (pins.address_lines == 11'h000) ? 1 : 0;
        end
    end
endmodule : nvsrc_dev_model
`default_nettype wire

//--- sim/tb_nvsrc_host.sv
// Self-checking bench for the nonvolatile SRAM host controller.
`default_nettype none
`define CHECK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) \
    begin fail_count++; $display("[FAIL] %s expected %h seen %h", \
    nm, ex, got); end end
module tb_nvsrc_host;
    timeunit 1ns;
    timeprecision 1ps;
    logic                   ref_clk   = 1'b0;
    logic                   reset     = 1'b1;
    logic                   supply_ok = 1'b1;
    nvsrc_pkg::nvsrc_req_t  req       = '0;
    logic                   ready;
    nvsrc_pkg::nvsrc_resp_t resp;
    nvsrc_pkg::nvsrc_pins_t pins;
    logic [7:0]             data_lines_in;
    int                     fail_count      = 0;
    int                     samples_checked = 0;
    logic                   rf;
    logic [7:0]             rd;
    int                     n;

    always #2.5 ref_clk = ~ref_clk;

    nvsrc_host #(.STORE_CYC(50), .RECALL_CYC(20), .RESTORE_CYC(30))
    i_nvsrc_host (.ref_clk(ref_clk), .reset(reset), .supply_ok(supply_ok),
        .req(req), .ready(ready), .resp(resp), .pins(pins),
        .data_lines_in(data_lines_in));
    nvsrc_dev_model i_nvsrc_dev_model (.ref_clk(ref_clk),
        .supply_ok(supply_ok), .pins(pins), .data_lines_in(data_lines_in));

    task final_report;
        $display("fail_count=%0d samples_checked=%0d", fail_count,
                 samples_checked);
        if (fail_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    task tick;
        @(posedge ref_clk);
        #1;
    endtask : tick

    task give_up;
        fail_count++;
        $display("[FAIL] handshake expected 1 seen 0");
        final_report();
    endtask : give_up

    // Returns the edges from acceptance to done in n.
    task do_op(input nvsrc_pkg::nvsrc_op_t op, input logic [10:0] a,
               input logic [7:0] wd);
        n = 0;
        while (ready !== 1'b1 && n < 1000)
        begin
            tick();
            n++;
        end
        if (n >= 1000)
            give_up();
        req.op = op;
        req.addr = a;
        req.wdata = wd;
        req.valid = 1'b1;
        tick();
        req.valid = 1'b0;
        n = 0;
        while (resp.done !== 1'b1 && n < 400)
        begin
            tick();
            n++;
        end
        if (n >= 400)
            give_up();
        rf = resp.refused;
        rd = resp.rdata;
        tick();
    endtask : do_op

    task sc_write_read;
        do_op(nvsrc_pkg::NVSRC_OP_WRITE, 11'h123, 8'hA5);
        `CHECK("write cycles", 18, n)
        do_op(nvsrc_pkg::NVSRC_OP_WRITE, 11'h7FF, 8'h3C);
        do_op(nvsrc_pkg::NVSRC_OP_READ, 11'h123, 8'h00);
        `CHECK("read 123", 8'hA5, rd)
        do_op(nvsrc_pkg::NVSRC_OP_READ, 11'h7FF, 8'h00);
        `CHECK("read 7FF", 8'h3C, rd)
    endtask : sc_write_read

    task sc_store_recall;
        do_op(nvsrc_pkg::NVSRC_OP_STORE, 11'h000, 8'h00);
        `CHECK("store refused", 1'b0, rf)
        `CHECK("store cycles", 6 * 18 + 50, n)
        do_op(nvsrc_pkg::NVSRC_OP_WRITE, 11'h123, 8'h5A);
        do_op(nvsrc_pkg::NVSRC_OP_RECALL, 11'h000, 8'h00);
        `CHECK("recall cycles", 6 * 18 + 20, n)
        do_op(nvsrc_pkg::NVSRC_OP_READ, 11'h123, 8'h00);
        `CHECK("recalled 123", 8'hA5, rd)
        do_op(nvsrc_pkg::NVSRC_OP_RECALL, 11'h000, 8'h00);
        do_op(nvsrc_pkg::NVSRC_OP_READ, 11'h123, 8'h00);
        `CHECK("second recall", 8'hA5, rd)
    endtask : sc_store_recall

    task sc_power;
        do_op(nvsrc_pkg::NVSRC_OP_WRITE, 11'h0F0, 8'h3C);
        supply_ok = 1'b0;
        repeat (5) tick();
        `CHECK("ready in brownout", 1'b0, ready)
        supply_ok = 1'b1;
        do_op(nvsrc_pkg::NVSRC_OP_READ, 11'h0F0, 8'h00);
        `CHECK("power cycle data", 8'h3C, rd)
    endtask : sc_power

    task sc_abort;
        fork
            do_op(nvsrc_pkg::NVSRC_OP_STORE, 11'h000, 8'h00);
            begin
                repeat (40) tick();
                supply_ok = 1'b0;
            end
        join
        `CHECK("aborted store", 1'b1, rf)
        supply_ok = 1'b1;
        do_op(nvsrc_pkg::NVSRC_OP_STORE, 11'h000, 8'h00);
        `CHECK("store after abort", 1'b0, rf)
        do_op(nvsrc_pkg::NVSRC_OP_READ, 11'h123, 8'h00);
        `CHECK("data after abort", 8'hA5, rd)
    endtask : sc_abort

    initial
    begin
        repeat (10) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        sc_write_read();
        sc_store_recall();
        sc_power();
        sc_abort();
        final_report();
    end
endmodule : tb_nvsrc_host
bind nvsrc_host nvsrc_host_asserts i_nvsrc_host_asserts (.ref_clk(ref_clk),
    .reset(reset), .supply_ok(supply_ok), .req(req), .ready(ready),
    .resp(resp), .pins(pins), .data_lines_in(data_lines_in));
`default_nettype wire
